// *** hw/dual_serial_map.svh ***
// Offsets, field positions, reset values and codes of the dual serial control block
`ifndef DUAL_SERIAL_MAP_SVH
`define DUAL_SERIAL_MAP_SVH

// ----------------------------------------------------------------
// Register pointer values
// ----------------------------------------------------------------
`define PTR_CMD 3'h0
`define PTR_COND 3'h1
`define PTR_VEC 3'h2
`define PTR_IMR 3'h1

// ----------------------------------------------------------------
// Command field codes
// ----------------------------------------------------------------
`define CMD_NULL 3'h0
`define CMD_ABORT 3'h1
`define CMD_EXT_RESET 3'h2
`define CMD_CHAN_RESET 3'h3
`define CMD_RX_NEXT 3'h4
`define CMD_TX_IP_RESET 3'h5
`define CMD_ERR_RESET 3'h6
`define CMD_RETI 3'h7

// ----------------------------------------------------------------
// Interrupt mode register fields
// ----------------------------------------------------------------
`define IMR_EXT_EN 0
`define IMR_TX_EN 1
`define IMR_SAV 2
`define IMR_RXM_HI 4
`define IMR_RXM_LO 3
`define RXM_OFF 2'h0
`define RXM_FIRST 2'h1
`define RXM_ALL_PAR 2'h2

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define ST_RX_AVAIL 0
`define ST_TX_EMPTY 2
`define ST_DCD 3
`define ST_SYNC 4
`define ST_CTS 5
`define ST_UNDERRUN 6
`define ST_BREAK 7
`define CS_PERR 4
`define CS_OERR 5
`define CS_FERR 6

// ----------------------------------------------------------------
// Vector condition codes, reset values, sizes
// ----------------------------------------------------------------
`define VC_TX 2'h0
`define VC_EXT 2'h1
`define VC_RX 2'h2
`define VC_SPEC 2'h3
`define VC_IDLE 3'h3
`define REG_RST 8'h00
`define TXF_DEPTH 16
`define DATA_W 8

`endif

// *** hw/dual_serial_pkg.sv ***
// Types shared by the dual serial control block
`default_nettype none
package dual_serial_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic perr;
		logic ferr;
	} rx_char_t;

	typedef struct packed {
		logic brk;
		logic underrun;
		logic sync;
		logic cts;
		logic dcd;
	} ext_t;

	typedef struct packed {
		logic [2:0] ptr;
		logic [7:0][7:0] wreg;
		logic avail;
		logic [7:0] rx_data;
		logic perr;
		logic oerr;
		logic ferr;
		logic armed;
		logic rx_ip;
		logic sp_ip;
		logic tx_ip;
		logic ext_ip;
		logic tx_busy;
		ext_t ext_lat;
		ext_t s1;
		ext_t s2;
	} chan_t;

	typedef struct packed {
		chan_t [1:0] ch;
		logic in_service;
		logic [7:0] dout;
		logic int_n;
		logic [7:0] vector;
	} ctrl_state_t;
endpackage : dual_serial_pkg
`default_nettype wire

// *** hw/tx_fifo.sv ***
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_state_t;

	fifo_state_t st;
	fifo_state_t next_st;
	logic push;
	logic pop;

	assign in_ready = (st.cnt != (AW+1)'(D));
	assign out_valid = (st.cnt != '0);
	assign out_data = st.mem[st.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = (st.wp == AW'(D-1)) ? '0 : AW'(st.wp + 1'b1);
		end
		if (pop) begin
			next_st.rp = (st.rp == AW'(D-1)) ? '0 : AW'(st.rp + 1'b1);
		end
		if (push && !pop) begin
			next_st.cnt = (AW+1)'(st.cnt + 1'b1);
		end else if (pop && !push) begin
			next_st.cnt = (AW+1)'(st.cnt - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : tx_fifo
`default_nettype wire

// *** hw/dual_serial_ctrl.sv ***
// Host control, pointer, command and vectored interrupt logic of a two-channel serial controller
`timescale 1ns/1ps
`default_nettype none
`include "dual_serial_map.svh"

// Summary of operation
// RL1 - Status-affects-vector bit in channel B rewrites vector bits by pending condition
// RL2 - Priority: channel A over B; receive over transmit over external status
// RL3 - Transmit interrupt when enabled and transmit buffer goes from loaded to empty
// RL4 - Receive interrupts on first character, every character, or special conditions
// RL5 - Every-character mode may count parity error as a special condition
// RL6 - Special conditions interrupt only in first-character or every-character modes
// RL7 - First-character mode: non-parity special conditions interrupt after first character
// RL8 - External status interrupt on CTS, DCD, sync, underrun and break changes
// RL9 - Break gives an external status interrupt at its start and at its end
// RL10 - Eight write registers; non-command ones take pointer byte then value
// RL11 - Any reset returns the pointer to the command register
// RL12 - Pointer also selects the read register returned on control reads
// RL13 - After any non-command register access the pointer reverts to command
// RL14 - Command bits 5:3 decode null, abort, ext reset, chan reset, etc.
// RL15 - Null command only loads the pointer
// RL16 - Vector write register exists only in channel B
// RL17 - Channel B read register returns vector modified by top condition
// RL18 - Condition status: parity bit 4, overrun bit 5, framing bit 6
// RL19 - Status bit 0 shows a received character is available
// RL20 - Parity and overrun stay latched until error reset command
// RL21 - External status bits stay latched until ext status reset command
// RL22 - Host waits four clocks after channel reset before further writes
// RL23 - Address bit 1 picks channel, bit 0 picks control versus data port
// RL24 - Status bit 2 shows transmit buffer can accept a character
module dual_serial_ctrl
	import dual_serial_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Host port
	input wire logic CS,
	input wire logic RD,
	input wire logic WR,
	input wire logic [1:0] ADDR,
	input wire logic [7:0] DIN,
	output logic [7:0] DOUT,
	// Interrupt
	input wire logic INTACK,
	output logic INT_N,
	output logic [7:0] VECTOR,
	// Character side, index 0 is channel A
	input wire logic [1:0] RX_VALID,
	input wire rx_char_t [1:0] RX_CHAR,
	output logic [1:0] TX_VALID,
	input wire logic [1:0] TX_READY,
	output logic [1:0][7:0] TX_DATA,
	// Modem and line status pins
	input wire logic [1:0] CTS_N,
	input wire logic [1:0] DCD_N,
	input wire logic [1:0] SYNC_N,
	input wire logic [1:0] BREAK_DET,
	input wire logic [1:0] TX_UNDERRUN
);
	ctrl_state_t st;
	ctrl_state_t next_st;
	logic [1:0] tx_in_ready;
	logic [1:0] tx_push;
	logic [7:0] vec_mod;
	logic [2:0] top_code;
	logic pending;

	// ----------------------------------------------------------------
	// Transmit buffers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tx
			assign tx_push[g] = CS && WR && (ADDR == {1'(g), 1'b0});
			tx_fifo #(.W(`DATA_W), .D(`TXF_DEPTH)) u_fifo (
				.clk(CLK),
				.rst_n(RST_N),
				.in_valid(tx_push[g]),
				.in_ready(tx_in_ready[g]),
				.in_data(DIN),
				.out_valid(TX_VALID[g]),
				.out_ready(TX_READY[g]),
				.out_data(TX_DATA[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Priority and vector
	// ----------------------------------------------------------------
	always_comb begin
		top_code = `VC_IDLE;
		pending = 1'b0;
		for (int c = 1; c >= 0; c--) begin
			if (st.ch[c].ext_ip) begin
				top_code = {c == 0, `VC_EXT}; // RL2
			end
			if (st.ch[c].tx_ip) begin
				top_code = {c == 0, `VC_TX}; // RL2
			end
			if (st.ch[c].rx_ip) begin
				top_code = {c == 0, `VC_RX}; // RL2
			end
			if (st.ch[c].sp_ip) begin
				top_code = {c == 0, `VC_SPEC}; // RL2
			end
			pending = pending | st.ch[c].ext_ip | st.ch[c].tx_ip | st.ch[c].rx_ip
				| st.ch[c].sp_ip;
		end
		vec_mod = {st.ch[1].wreg[`PTR_VEC][7:4], top_code, st.ch[1].wreg[`PTR_VEC][0]}; // RL1
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] imr;
		logic [1:0] mode;
		logic sel;
		logic new_ovr;
		logic special;
		ext_t pins;
		logic [7:0] rr0;
		logic [7:0] rr1;
		imr = '0;
		mode = '0;
		sel = 1'b0;
		new_ovr = 1'b0;
		special = 1'b0;
		pins = '0;
		rr0 = '0;
		rr1 = '0;
		next_st = st;
		for (int c = 0; c < 2; c++) begin
			imr = st.ch[c].wreg[`PTR_IMR];
			mode = imr[`IMR_RXM_HI:`IMR_RXM_LO];
			sel = CS && (ADDR[1] == 1'(c)); // RL23
			pins = '{brk: BREAK_DET[c], underrun: TX_UNDERRUN[c], sync: !SYNC_N[c],
				cts: !CTS_N[c], dcd: !DCD_N[c]};
			next_st.ch[c].s1 = pins;
			next_st.ch[c].s2 = st.ch[c].s1;
			rr0 = '0;
			rr0[`ST_RX_AVAIL] = st.ch[c].avail; // RL19
			rr0[`ST_TX_EMPTY] = tx_in_ready[c]; // RL24
			rr0[`ST_DCD] = st.ch[c].ext_lat.dcd;
			rr0[`ST_SYNC] = st.ch[c].ext_lat.sync;
			rr0[`ST_CTS] = st.ch[c].ext_lat.cts;
			rr0[`ST_UNDERRUN] = st.ch[c].ext_lat.underrun;
			rr0[`ST_BREAK] = st.ch[c].ext_lat.brk;
			rr1 = '0;
			rr1[`CS_PERR] = st.ch[c].perr; // RL18
			rr1[`CS_OERR] = st.ch[c].oerr; // RL18
			rr1[`CS_FERR] = st.ch[c].ferr; // RL18
			// Host accesses, placed before events so that a set wins over a clear
			if (sel && WR && ADDR[0]) begin
				if (st.ch[c].ptr == `PTR_CMD) begin
					next_st.ch[c].ptr = DIN[2:0]; // RL10 RL15
					unique case (DIN[5:3]) // RL14
						`CMD_EXT_RESET: next_st.ch[c].ext_ip = 1'b0; // RL21
						`CMD_CHAN_RESET: begin
							next_st.ch[c] = '0; // RL11
							next_st.ch[c].s1 = pins;
							next_st.ch[c].s2 = st.ch[c].s1;
							if (c == 0) begin
								next_st.in_service = 1'b0;
							end
						end
						`CMD_RX_NEXT: next_st.ch[c].armed = 1'b1;
						`CMD_TX_IP_RESET: next_st.ch[c].tx_ip = 1'b0;
						`CMD_ERR_RESET: begin
							next_st.ch[c].perr = 1'b0; // RL20
							next_st.ch[c].oerr = 1'b0; // RL20
							next_st.ch[c].sp_ip = 1'b0;
						end
						`CMD_RETI: begin
							if (c == 0) begin
								next_st.in_service = 1'b0;
							end
						end
						`CMD_NULL, `CMD_ABORT: begin
						end
					endcase
				end else begin
					if (!(st.ch[c].ptr == `PTR_VEC && c == 0)) begin // RL16
						next_st.ch[c].wreg[st.ch[c].ptr] = DIN; // RL10
					end
					next_st.ch[c].ptr = `PTR_CMD; // RL13
				end
			end
			if (sel && WR && !ADDR[0]) begin
				next_st.ch[c].tx_ip = 1'b0;
			end
			if (sel && RD && ADDR[0]) begin
				unique case (st.ch[c].ptr) // RL12
					`PTR_CMD: next_st.dout = rr0;
					`PTR_COND: next_st.dout = rr1;
					`PTR_VEC: next_st.dout = (c == 1) ? vec_mod : `REG_RST; // RL17
					default: next_st.dout = `REG_RST;
				endcase
				next_st.ch[c].ptr = `PTR_CMD; // RL13
			end
			if (sel && RD && !ADDR[0]) begin
				next_st.dout = st.ch[c].rx_data;
				next_st.ch[c].avail = 1'b0;
				next_st.ch[c].rx_ip = 1'b0;
			end
			// External status: latch on change until reset command
			if (!st.ch[c].ext_ip) begin
				next_st.ch[c].ext_lat = st.ch[c].s2; // RL21
				if (imr[`IMR_EXT_EN] && st.ch[c].s2 != st.ch[c].ext_lat) begin
					next_st.ch[c].ext_ip = 1'b1; // RL8 RL9
				end
			end
			// Transmit buffer becoming empty
			next_st.ch[c].tx_busy = TX_VALID[c];
			if (imr[`IMR_TX_EN] && st.ch[c].tx_busy && !TX_VALID[c]) begin
				next_st.ch[c].tx_ip = 1'b1; // RL3
			end
			// Received character
			if (RX_VALID[c]) begin
				new_ovr = st.ch[c].avail;
				next_st.ch[c].avail = 1'b1;
				next_st.ch[c].rx_data = RX_CHAR[c].data;
				next_st.ch[c].ferr = RX_CHAR[c].ferr;
				next_st.ch[c].perr = next_st.ch[c].perr | RX_CHAR[c].perr; // RL20
				next_st.ch[c].oerr = next_st.ch[c].oerr | new_ovr; // RL20
				special = new_ovr || RX_CHAR[c].ferr
					|| (RX_CHAR[c].perr && mode == `RXM_ALL_PAR); // RL5
				if (mode != `RXM_OFF && special
					&& !(mode == `RXM_FIRST && st.ch[c].armed)) begin
					next_st.ch[c].sp_ip = 1'b1; // RL4 RL6 RL7
				end
				if (mode == `RXM_FIRST && st.ch[c].armed) begin
					next_st.ch[c].rx_ip = 1'b1; // RL4
					next_st.ch[c].armed = 1'b0;
				end else if (mode[1]) begin
					next_st.ch[c].rx_ip = 1'b1; // RL4
				end
			end
		end
		// Interrupt request and acknowledge
		next_st.int_n = !(pending && !st.in_service);
		if (INTACK && pending && !st.in_service) begin
			next_st.in_service = 1'b1;
			next_st.vector = st.ch[1].wreg[`PTR_IMR][`IMR_SAV] ? vec_mod
				: st.ch[1].wreg[`PTR_VEC]; // RL1
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0; // RL11
			st.int_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign DOUT = st.dout;
	assign INT_N = st.int_n;
	assign VECTOR = st.vector;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_ptr_revert;
		CS && WR && ADDR == 2'h1 && st.ch[0].ptr != `PTR_CMD |=> st.ch[0].ptr == `PTR_CMD;
	endproperty
	a_ptr_revert: assert property (p_ptr_revert) else $error("pointer did not revert"); // RL13

	property p_ptr_load;
		CS && WR && ADDR == 2'h3 && st.ch[1].ptr == `PTR_CMD && DIN[5:3] == `CMD_NULL
			|=> st.ch[1].ptr == $past(DIN[2:0]);
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // RL15

	property p_chan_reset;
		CS && WR && ADDR == 2'h1 && st.ch[0].ptr == `PTR_CMD && DIN[5:3] == `CMD_CHAN_RESET
			|=> st.ch[0].ptr == `PTR_CMD && !st.ch[0].armed && !st.in_service;
	endproperty
	a_chan_reset: assert property (p_chan_reset) else $error("channel reset incomplete"); // RL11

	property p_prio;
		(st.ch[0].rx_ip || st.ch[0].sp_ip) |-> top_code[2] && top_code[1];
	endproperty
	a_prio: assert property (p_prio) else $error("channel A receive not on top"); // RL2

	property p_sav;
		INTACK && pending && !st.in_service && st.ch[1].wreg[`PTR_IMR][`IMR_SAV]
			|=> VECTOR[3:1] == $past(top_code) ##1 INT_N;
	endproperty
	a_sav: assert property (p_sav) else $error("vector not modified"); // RL1

	property p_tx_ip;
		st.ch[0].wreg[`PTR_IMR][`IMR_TX_EN] && st.ch[0].tx_busy && !TX_VALID[0]
			|=> st.ch[0].tx_ip;
	endproperty
	a_tx_ip: assert property (p_tx_ip) else $error("transmit empty not flagged"); // RL3

	property p_rr1;
		CS && RD && ADDR == 2'h3 && st.ch[1].ptr == `PTR_COND
			|=> DOUT[6:4] == $past({st.ch[1].ferr, st.ch[1].oerr, st.ch[1].perr});
	endproperty
	a_rr1: assert property (p_rr1) else $error("condition status wrong"); // RL18

	property p_rx_avail;
		CS && RD && ADDR == 2'h1 && st.ch[0].ptr == `PTR_CMD && st.ch[0].avail |=> DOUT[0];
	endproperty
	a_rx_avail: assert property (p_rx_avail) else $error("character not shown available"); // RL19

	property p_err_hold;
		st.ch[1].oerr && !(CS && WR && ADDR == 2'h3) |=> st.ch[1].oerr;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("overrun latch lost"); // RL20

	property p_no_vec_a;
		CS && WR && ADDR == 2'h1 && st.ch[0].ptr == `PTR_VEC
			|=> st.ch[0].wreg[`PTR_VEC] == $past(st.ch[0].wreg[`PTR_VEC]);
	endproperty
	a_no_vec_a: assert property (p_no_vec_a) else $error("channel A vector written"); // RL16

	c_intack: cover property (INTACK && pending && !st.in_service);
	c_ext: cover property (st.ch[0].ext_ip && st.ch[0].ext_lat.brk);
	c_tx_full: cover property (!tx_in_ready[0]);
endmodule : dual_serial_ctrl
`default_nettype wire

// *** tb/host_bus_model.sv ***
// Host processor model driving the parallel control port
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	// Bus
	input wire logic clk,
	output logic cs,
	output logic rd,
	output logic wr,
	output logic [1:0] addr,
	output logic [7:0] din,
	input wire logic [7:0] dout
);
	initial begin
		cs = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 2'h0;
		din = 8'h00;
	end

	// Single write; released data is inverted
	task automatic put(input logic [1:0] a, input logic [7:0] d);
		@(negedge clk);
		cs = 1'b1;
		wr = 1'b1;
		addr = a;
		din = d;
		@(negedge clk);
		cs = 1'b0;
		wr = 1'b0;
		din = ~d;
	endtask : put

	// Single read; data taken once settled
	task automatic get(input logic [1:0] a, output logic [7:0] d);
		@(negedge clk);
		cs = 1'b1;
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		cs = 1'b0;
		rd = 1'b0;
		@(negedge clk);
		d = dout;
	endtask : get

	// Pointer byte then value
	task automatic reg_w(input logic [1:0] a, input logic [2:0] p, input logic [7:0] d);
		put(a, {5'h00, p});
		put(a, d);
	endtask : reg_w

	// Pointer byte then read
	task automatic reg_r(input logic [1:0] a, input logic [2:0] p, output logic [7:0] d);
		put(a, {5'h00, p});
		get(a, d);
	endtask : reg_r

	// Channel reset with recovery gap
	task automatic chan_reset(input logic [1:0] a);
		put(a, 8'h19);
		repeat (4) @(negedge clk);
	endtask : chan_reset
endmodule : host_bus_model
`default_nettype wire

// *** tb/tb_dual_serial_ctrl.sv ***
// Self-checking testbench of the dual serial control block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_serial_ctrl;
	import dual_serial_pkg::*;
	logic clk;
	logic rst_n;
	logic cs;
	logic rd;
	logic wr;
	logic [1:0] addr;
	logic [7:0] din;
	logic [7:0] dout;
	logic intack;
	logic int_n;
	logic [7:0] vector;
	logic [1:0] rx_valid;
	rx_char_t [1:0] rx_char;
	logic [1:0] tx_valid;
	logic [1:0] tx_ready;
	logic [1:0][7:0] tx_data;
	logic [1:0] cts_n;
	logic [1:0] dcd_n;
	logic [1:0] sync_n;
	logic [1:0] brk;
	logic [1:0] und;
	int fail_count = 0;
	int compares = 0;
	logic [7:0] d;

	dual_serial_ctrl u_dut (.CLK(clk), .RST_N(rst_n), .CS(cs), .RD(rd), .WR(wr),
		.ADDR(addr), .DIN(din), .DOUT(dout), .INTACK(intack), .INT_N(int_n),
		.VECTOR(vector), .RX_VALID(rx_valid), .RX_CHAR(rx_char), .TX_VALID(tx_valid),
		.TX_READY(tx_ready), .TX_DATA(tx_data), .CTS_N(cts_n), .DCD_N(dcd_n),
		.SYNC_N(sync_n), .BREAK_DET(brk), .TX_UNDERRUN(und));
	host_bus_model u_host (.clk(clk), .cs(cs), .rd(rd), .wr(wr), .addr(addr),
		.din(din), .dout(dout));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic test_done;
		$display("Comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	task automatic rx(input int ch, input logic [7:0] v, input logic [1:0] e);
		@(negedge clk);
		rx_char[ch] = {v, e};
		rx_valid[ch] = 1'b1;
		@(negedge clk);
		rx_valid[ch] = 1'b0;
	endtask : rx

	task automatic ack(input logic [7:0] exp);
		repeat (4) @(negedge clk);
		check("int_n", int_n, 8'h00);
		intack = 1'b1;
		@(negedge clk);
		intack = 1'b0;
		repeat (2) @(negedge clk);
		check("vector", vector, exp);
		check("int_n", int_n, 8'h01);
	endtask : ack

	task automatic pin(input int i, input logic on);
		case (i)
			0: dcd_n[0] = ~on;
			1: sync_n[0] = ~on;
			2: cts_n[0] = ~on;
			3: und[0] = on;
			default: brk[0] = on;
		endcase
	endtask : pin

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_ptr;
		u_host.get(2'h1, d);
		check("status", d, 8'h04);
		u_host.reg_r(2'h1, 3'h1, d);
		check("cond", d, 8'h00);
		u_host.get(2'h1, d);
		check("status", d, 8'h04);
		u_host.reg_w(2'h3, 3'h2, 8'h40);
		u_host.reg_w(2'h1, 3'h2, 8'hff);
		u_host.reg_r(2'h1, 3'h2, d);
		check("vec_a", d, 8'h00);
		u_host.reg_r(2'h3, 3'h2, d);
		check("vec_b", d, 8'h46);
		u_host.put(2'h1, 8'h00);
		u_host.get(2'h1, d);
		check("null", d, 8'h04);
		u_host.chan_reset(2'h3);
		u_host.get(2'h3, d);
		check("chan_rst", d, 8'h04);
		u_host.reg_r(2'h3, 3'h2, d);
		check("vec_rst", d, 8'h06);
		u_host.chan_reset(2'h1);
		u_host.get(2'h1, d);
		check("chan_rst_a", d, 8'h04);
		u_host.reg_w(2'h3, 3'h2, 8'h40);
		$display("test pointer done");
	endtask : t_ptr

	task automatic t_rx_err;
		rx(1, 8'h5a, 2'b10);
		u_host.get(2'h3, d);
		check("avail", d, 8'h05);
		rx(1, 8'ha5, 2'b00);
		u_host.reg_r(2'h3, 3'h1, d);
		check("cond", d, 8'h30);
		u_host.get(2'h2, d);
		check("data", d, 8'ha5);
		u_host.reg_r(2'h3, 3'h1, d);
		check("cond", d, 8'h30);
		u_host.put(2'h3, 8'h30);
		u_host.reg_r(2'h3, 3'h1, d);
		check("cond", d, 8'h00);
		rx(1, 8'h11, 2'b01);
		u_host.reg_r(2'h3, 3'h1, d);
		check("ferr", d, 8'h40);
		u_host.get(2'h2, d);
		$display("test rx errors done");
	endtask : t_rx_err

	task automatic t_tx;
		tx_ready = 2'h0;
		u_host.reg_w(2'h1, 3'h1, 8'h02);
		for (int k = 0; k < 16; k++) begin
			u_host.put(2'h0, 8'h30 + 8'(k));
		end
		u_host.put(2'h0, 8'hee);
		u_host.get(2'h1, d);
		check("full", d, 8'h00);
		u_host.put(2'h2, 8'h99);
		check("tx_b", tx_data[1], 8'h99);
		check("tx_valid_b", {7'h00, tx_valid[1]}, 8'h01);
		@(negedge clk);
		tx_ready = 2'h3;
		for (int k = 0; k < 16; k++) begin
			check("tx_data", tx_data[0], 8'h30 + 8'(k));
			@(negedge clk);
		end
		check("tx_valid", {7'h00, tx_valid[0]}, 8'h00);
		ack(8'h40);
		u_host.put(2'h1, 8'h28);
		u_host.put(2'h1, 8'h38);
		repeat (4) @(negedge clk);
		check("int_n", int_n, 8'h01);
		$display("test transmit done");
	endtask : t_tx

	task automatic t_prio;
		u_host.reg_w(2'h1, 3'h1, 8'h10);
		u_host.reg_w(2'h3, 3'h1, 8'h1c);
		rx(1, 8'h22, 2'b00);
		rx(0, 8'h33, 2'b10);
		ack(8'h4e);
		u_host.get(2'h1, d);
		check("avail_a", d, 8'h05);
		u_host.put(2'h1, 8'h30);
		u_host.get(2'h0, d);
		u_host.put(2'h1, 8'h38);
		ack(8'h44);
		u_host.get(2'h2, d);
		check("data", d, 8'h22);
		u_host.put(2'h1, 8'h38);
		rx(1, 8'h44, 2'b10);
		ack(8'h44);
		u_host.get(2'h2, d);
		u_host.put(2'h3, 8'h30);
		u_host.put(2'h1, 8'h38);
		$display("test priority done");
	endtask : t_prio

	task automatic t_first;
		u_host.reg_w(2'h3, 3'h1, 8'h0c);
		u_host.put(2'h3, 8'h20);
		rx(1, 8'h55, 2'b00);
		ack(8'h44);
		u_host.get(2'h2, d);
		u_host.put(2'h1, 8'h38);
		rx(1, 8'h66, 2'b10);
		repeat (6) @(negedge clk);
		check("no_par_int", int_n, 8'h01);
		rx(1, 8'h77, 2'b00);
		ack(8'h46);
		u_host.put(2'h3, 8'h30);
		u_host.get(2'h2, d);
		u_host.put(2'h1, 8'h38);
		u_host.reg_w(2'h3, 3'h1, 8'h04);
		rx(1, 8'h01, 2'b10);
		rx(1, 8'h02, 2'b00);
		repeat (6) @(negedge clk);
		check("mode_off", int_n, 8'h01);
		u_host.get(2'h2, d);
		u_host.put(2'h3, 8'h30);
		$display("test first char done");
	endtask : t_first

	task automatic t_ext;
		u_host.reg_w(2'h1, 3'h1, 8'h01);
		for (int i = 0; i < 5; i++) begin
			pin(i, 1'b1);
			repeat (8) @(negedge clk);
			check("ext_on", int_n, 8'h00);
			u_host.get(2'h1, d);
			check("ext_st", d, 8'h04 | (8'h08 << i));
			u_host.put(2'h1, 8'h10);
			repeat (8) @(negedge clk);
			check("ext_clr", int_n, 8'h01);
			pin(i, 1'b0);
			repeat (8) @(negedge clk);
			check("ext_off", int_n, 8'h00);
			pin(i, 1'b1);
			repeat (8) @(negedge clk);
			u_host.get(2'h1, d);
			check("latch", d, 8'h04);
			pin(i, 1'b0);
			repeat (8) @(negedge clk);
			u_host.put(2'h1, 8'h10);
			repeat (8) @(negedge clk);
			check("ext_clr", int_n, 8'h01);
		end
		$display("test ext status done");
	endtask : t_ext

	// ----------------------------------------------------------------
	// Clock, reset, sequence, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		intack = 1'b0;
		rx_valid = 2'h0;
		rx_char = '0;
		tx_ready = 2'h3;
		cts_n = 2'h3;
		dcd_n = 2'h3;
		sync_n = 2'h3;
		brk = 2'h0;
		und = 2'h0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_ptr();
		t_rx_err();
		t_tx();
		t_prio();
		t_first();
		t_ext();
		test_done();
	end

	initial begin
		#200000;
		fail_count++;
		test_done();
	end
endmodule : tb_dual_serial_ctrl
`default_nettype wire
